// ### verilog/ocd_pkg.sv
// constants for the overlay chroma descriptor dma channel
package ocd_pkg;
   // register byte addresses
   localparam logic [31:0] UUV_CTRL_ADDR = 32'hF80382B4;
   localparam logic [31:0] UUV_NEXT_ADDR = 32'hF80382B8;
   localparam logic [31:0] V_HEAD_ADDR = 32'hF80382BC;
   localparam logic [31:0] V_START_ADDR = 32'hF80382C0;
   localparam logic [31:0] V_CTRL_ADDR = 32'hF80382C4;
   localparam logic [31:0] V_NEXT_ADDR = 32'hF80382C8;
   localparam logic [31:0] BUS_CFG_ADDR = 32'hF80382CC;
   localparam logic [31:0] V_STATUS_ADDR = 32'hF80383F0;
   localparam logic [31:0] RESET_WORD = 32'h00000000;
   // channel control bit positions
   localparam int CTRL_FETCH = 0;
   localparam int CTRL_XFER_IRQ = 2;
   localparam int CTRL_LOAD_IRQ = 3;
   localparam int CTRL_ADD_IRQ = 4;
   localparam int CTRL_END_IRQ = 5;
   localparam logic [31:0] UUV_CTRL_MASK = 32'h00000021;
   localparam logic [31:0] V_CTRL_MASK = 32'h0000003D;
   // bus configuration field positions
   localparam int CFG_YBL_LO = 4;
   localparam int CFG_CBL_LO = 6;
   localparam int CFG_FIXED = 8;
   localparam int CFG_ROT_OFF = 12;
   localparam int CFG_LOCK_OFF = 13;
   localparam logic [31:0] CFG_MASK = 32'h000031F0;
   // status bit positions
   localparam int STAT_FETCH = 0;
   localparam int STAT_RUN = 1;
   localparam int STAT_PEND = 2;
   // burst length settings
   localparam logic [1:0] BL_SINGLE = 2'h0;
   localparam logic [1:0] BL_FOUR = 2'h1;
   localparam logic [1:0] BL_EIGHT = 2'h2;
   localparam logic [1:0] BL_SIXTEEN = 2'h3;
   // bus burst encodings
   localparam logic [2:0] HB_SINGLE = 3'h0;
   localparam logic [2:0] HB_INCR = 3'h1;
   localparam logic [2:0] HB_INCR4 = 3'h3;
   localparam logic [2:0] HB_INCR8 = 3'h5;
   localparam logic [2:0] HB_INCR16 = 3'h7;
   // word counts
   localparam logic [5:0] W1 = 6'h01;
   localparam logic [5:0] W2 = 6'h02;
   localparam logic [5:0] W4 = 6'h04;
   localparam logic [5:0] W8 = 6'h08;
   localparam logic [5:0] W16 = 6'h10;
   typedef enum {V_IDLE, V_FETCH, V_RUN} ocd_vstate_t;
endpackage

// ### verilog/ocd_chroma_dma.sv
// register file, descriptor sequencer and burst planner of the overlay chroma dma
//
// What this block does
// - uuv end-of-list event reaches its irq output only when enable bit is 1.
// - writing the v head pointer queues a new descriptor for fetching.
// - v start address register holds the v plane fetch address.
// - v next register holds the address of the following v descriptor.
// - v control bit 0 set allows descriptor fetches, clear stops them.
// - v control bit 2 at 0 enables transfer-done irq, 1 disables.
// - v control bit 3 at 0 enables descriptor-loaded irq, 1 disables.
// - v control bit 4 at 0 enables head-queued irq, 1 disables.
// - v control bit 5 at 1 enables v end-of-list irq.
// - y setting 0 starts at one free word, any burst type allowed.
// - y settings 1,2,3 wait for 4,8,16 free words, prefer matching burst.
// - setting caps burst size: four allows INCR4, eight INCR8, INCR16 else.
// - bursts of 2 or 3 beats use undefined-length INCR.
// - chroma burst setting uses the same four encodings.
// - fixed-length bit 1 forbids INCR; only SINGLE and fixed bursts.
// - config bit 12 at 1 turns rotation fetch optimisation off.
// - config bit 13 at 0 locks the bus during rotation while a y or chroma burst is requested, 1 never.
// - uuv control bit 0 set enables uuv descriptor fetching.
`timescale 1ns/100ps
module ocd_chroma_dma
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // register port
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // uuv channel
   input wire logic uuv_list_end,
   output logic uuv_desc_fetch_en,
   output logic [31:0] uuv_next_desc_addr,
   output logic uuv_list_end_irq,
   // v descriptor sequencer
   output logic v_desc_req,
   output logic [31:0] v_desc_addr,
   input wire logic v_desc_ack,
   input wire logic [31:0] v_desc_start_in,
   input wire logic [31:0] v_desc_next_in,
   input wire logic v_xfer_done,
   output logic [31:0] v_fetch_addr,
   output logic v_xfer_done_irq,
   output logic v_desc_loaded_irq,
   output logic v_queue_add_irq,
   output logic v_list_end_irq,
   // y burst planner
   input wire logic [5:0] y_fifo_room,
   input wire logic [15:0] y_beats_left,
   output logic y_req,
   output logic [2:0] y_hburst,
   output logic [4:0] y_beats,
   // chroma burst planner
   input wire logic [5:0] c_fifo_room,
   input wire logic [15:0] c_beats_left,
   output logic c_req,
   output logic [2:0] c_hburst,
   output logic [4:0] c_beats,
   // rotation
   input wire logic rotate_active,
   output logic rotation_opt_en,
   output logic bus_lock
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [31:0] uuv_ctrl;
      logic [31:0] uuv_next;
      logic [31:0] v_head;
      logic [31:0] v_start;
      logic [31:0] v_ctrl;
      logic [31:0] v_next;
      logic [31:0] cfg;
      logic [31:0] rdata;
      ocd_pkg::ocd_vstate_t vst;
      logic pend;
      logic [31:0] desc_addr;
      logic uuv_end_irq;
      logic xfer_irq;
      logic load_irq;
      logic add_irq;
      logic end_irq;
      logic [8:0] y_plan;
      logic [8:0] c_plan;
      logic lock;
   } ocd_state_t;

   ocd_state_t st_q;
   ocd_state_t st_d;

   // ------------------------------------------------------------
   // burst planner: {go, hburst, beats}
   // ------------------------------------------------------------
   function automatic logic [8:0] plan_f(input logic [1:0] bl, input logic fixed,
                                         input logic [5:0] room, input logic [15:0] left);
      logic [5:0] thr;
      logic [5:0] cap;
      logic [5:0] n;
      logic go;
      logic [2:0] hb;
      logic [4:0] bt;
      case (bl)
         ocd_pkg::BL_FOUR:
         begin
            thr = ocd_pkg::W4;
            cap = ocd_pkg::W4;
         end
         ocd_pkg::BL_EIGHT:
         begin
            thr = ocd_pkg::W8;
            cap = ocd_pkg::W8;
         end
         ocd_pkg::BL_SIXTEEN:
         begin
            thr = ocd_pkg::W16;
            cap = ocd_pkg::W16;
         end
         default:
         begin
            thr = ocd_pkg::W1;
            cap = ocd_pkg::W16;
         end
      endcase
      n = room;
      if (left < {10'h000, room})
      begin
         n = left[5:0];
      end
      if (n > cap)
      begin
         n = cap;
      end
      go = (room >= thr) && (left != 16'h0000);
      if (n >= ocd_pkg::W16)
      begin
         hb = ocd_pkg::HB_INCR16;
         bt = ocd_pkg::W16[4:0];
      end
      else if (n >= ocd_pkg::W8)
      begin
         hb = ocd_pkg::HB_INCR8;
         bt = ocd_pkg::W8[4:0];
      end
      else if (n >= ocd_pkg::W4)
      begin
         hb = ocd_pkg::HB_INCR4;
         bt = ocd_pkg::W4[4:0];
      end
      else if (n >= ocd_pkg::W2 && !fixed)
      begin
         hb = ocd_pkg::HB_INCR;
         bt = n[4:0];
      end
      else
      begin
         hb = ocd_pkg::HB_SINGLE;
         bt = ocd_pkg::W1[4:0];
      end
      return {go, hb, bt};
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic wr_uuv_ctrl;
   logic wr_v_head;
   logic [31:0] rd_mux;

   always_comb
   begin
      st_d = st_q;
      wr_uuv_ctrl = reg_wr && reg_addr == ocd_pkg::UUV_CTRL_ADDR;
      wr_v_head = reg_wr && reg_addr == ocd_pkg::V_HEAD_ADDR;
      // register writes, reserved bits masked
      if (wr_uuv_ctrl)
      begin
         st_d.uuv_ctrl = reg_wdata & ocd_pkg::UUV_CTRL_MASK;
      end
      if (reg_wr && reg_addr == ocd_pkg::UUV_NEXT_ADDR)
      begin
         st_d.uuv_next = reg_wdata;
      end
      if (wr_v_head)
      begin
         st_d.v_head = reg_wdata;
      end
      if (reg_wr && reg_addr == ocd_pkg::V_START_ADDR)
      begin
         st_d.v_start = reg_wdata;
      end
      if (reg_wr && reg_addr == ocd_pkg::V_CTRL_ADDR)
      begin
         st_d.v_ctrl = reg_wdata & ocd_pkg::V_CTRL_MASK;
      end
      if (reg_wr && reg_addr == ocd_pkg::V_NEXT_ADDR)
      begin
         st_d.v_next = reg_wdata;
      end
      if (reg_wr && reg_addr == ocd_pkg::BUS_CFG_ADDR)
      begin
         st_d.cfg = reg_wdata & ocd_pkg::CFG_MASK;
      end
      // event pulses
      st_d.uuv_end_irq = uuv_list_end && st_q.uuv_ctrl[ocd_pkg::CTRL_END_IRQ];
      st_d.add_irq = wr_v_head && !st_q.v_ctrl[ocd_pkg::CTRL_ADD_IRQ];
      st_d.load_irq = 1'b0;
      st_d.xfer_irq = 1'b0;
      st_d.end_irq = 1'b0;
      // v descriptor sequencer
      case (st_q.vst)
         ocd_pkg::V_IDLE:
         begin
            if (st_q.pend && st_q.v_ctrl[ocd_pkg::CTRL_FETCH])
            begin
               st_d.vst = ocd_pkg::V_FETCH;
               st_d.desc_addr = st_q.v_head;
               st_d.pend = 1'b0;
            end
         end
         ocd_pkg::V_FETCH:
         begin
            if (v_desc_ack)
            begin
               st_d.v_start = v_desc_start_in;
               st_d.v_next = v_desc_next_in;
               st_d.load_irq = !st_q.v_ctrl[ocd_pkg::CTRL_LOAD_IRQ];
               st_d.vst = ocd_pkg::V_RUN;
            end
         end
         ocd_pkg::V_RUN:
         begin
            if (v_xfer_done)
            begin
               st_d.xfer_irq = !st_q.v_ctrl[ocd_pkg::CTRL_XFER_IRQ];
               if (st_q.v_ctrl[ocd_pkg::CTRL_FETCH] && st_q.v_next[31:2] != 30'h0)
               begin
                  st_d.vst = ocd_pkg::V_FETCH;
                  st_d.desc_addr = st_q.v_next;
               end
               else
               begin
                  st_d.vst = ocd_pkg::V_IDLE;
                  st_d.end_irq = st_q.v_ctrl[ocd_pkg::CTRL_END_IRQ];
               end
            end
         end
         default:
         begin
            st_d.vst = ocd_pkg::V_IDLE;
         end
      endcase
      // a head write in the cycle the pending flag is consumed wins
      if (wr_v_head)
      begin
         st_d.pend = 1'b1;
      end
      // burst planners
      st_d.y_plan = plan_f(st_q.cfg[ocd_pkg::CFG_YBL_LO +: 2], st_q.cfg[ocd_pkg::CFG_FIXED],
                           y_fifo_room, y_beats_left);
      st_d.c_plan = plan_f(st_q.cfg[ocd_pkg::CFG_CBL_LO +: 2], st_q.cfg[ocd_pkg::CFG_FIXED],
                           c_fifo_room, c_beats_left);
      st_d.lock = rotate_active && !st_q.cfg[ocd_pkg::CFG_LOCK_OFF]
                  && (st_d.y_plan[8] || st_d.c_plan[8]);
      // read port, data valid only in the cycle after the strobe
      case (reg_addr)
         ocd_pkg::UUV_CTRL_ADDR: rd_mux = st_q.uuv_ctrl;
         ocd_pkg::UUV_NEXT_ADDR: rd_mux = st_q.uuv_next;
         ocd_pkg::V_HEAD_ADDR: rd_mux = st_q.v_head;
         ocd_pkg::V_START_ADDR: rd_mux = st_q.v_start;
         ocd_pkg::V_CTRL_ADDR: rd_mux = st_q.v_ctrl;
         ocd_pkg::V_NEXT_ADDR: rd_mux = st_q.v_next;
         ocd_pkg::BUS_CFG_ADDR: rd_mux = st_q.cfg;
         ocd_pkg::V_STATUS_ADDR:
         begin
            rd_mux = ocd_pkg::RESET_WORD;
            rd_mux[ocd_pkg::STAT_FETCH] = st_q.vst == ocd_pkg::V_FETCH;
            rd_mux[ocd_pkg::STAT_RUN] = st_q.vst == ocd_pkg::V_RUN;
            rd_mux[ocd_pkg::STAT_PEND] = st_q.pend;
         end
         default: rd_mux = ocd_pkg::RESET_WORD;
      endcase
      st_d.rdata = reg_rd ? rd_mux : ocd_pkg::RESET_WORD;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= '0;
         st_q.vst <= ocd_pkg::V_IDLE;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign reg_rdata = st_q.rdata;
   assign uuv_desc_fetch_en = st_q.uuv_ctrl[ocd_pkg::CTRL_FETCH];
   assign uuv_next_desc_addr = st_q.uuv_next;
   assign uuv_list_end_irq = st_q.uuv_end_irq;
   assign v_desc_req = st_q.vst == ocd_pkg::V_FETCH;
   assign v_desc_addr = st_q.desc_addr;
   assign v_fetch_addr = st_q.v_start;
   assign v_xfer_done_irq = st_q.xfer_irq;
   assign v_desc_loaded_irq = st_q.load_irq;
   assign v_queue_add_irq = st_q.add_irq;
   assign v_list_end_irq = st_q.end_irq;
   assign y_req = st_q.y_plan[8];
   assign y_hburst = st_q.y_plan[7:5];
   assign y_beats = st_q.y_plan[4:0];
   assign c_req = st_q.c_plan[8];
   assign c_hburst = st_q.c_plan[7:5];
   assign c_beats = st_q.c_plan[4:0];
   assign rotation_opt_en = !st_q.cfg[ocd_pkg::CFG_ROT_OFF];
   assign bus_lock = st_q.lock;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking ck @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   uuv_end_gate_a: assert property (uuv_list_end |=>
      uuv_list_end_irq == $past(st_q.uuv_ctrl[ocd_pkg::CTRL_END_IRQ]))
      else $error("uuv end irq not gated by enable");
   fetch_gate_a: assert property ($rose(v_desc_req) |->
      $past(st_q.v_ctrl[ocd_pkg::CTRL_FETCH]))
      else $error("descriptor fetch started while disabled");
   head_fetch_a: assert property (wr_v_head ##1 (st_q.vst == ocd_pkg::V_IDLE
      && st_q.v_ctrl[ocd_pkg::CTRL_FETCH]) |=> v_desc_req && v_desc_addr == $past(st_q.v_head))
      else $error("queued head not fetched");
   xfer_irq_a: assert property ((st_q.vst == ocd_pkg::V_RUN && v_xfer_done) |=>
      v_xfer_done_irq != $past(st_q.v_ctrl[ocd_pkg::CTRL_XFER_IRQ]))
      else $error("transfer done irq polarity wrong");
   load_irq_a: assert property ((v_desc_req && v_desc_ack) |=>
      v_desc_loaded_irq != $past(st_q.v_ctrl[ocd_pkg::CTRL_LOAD_IRQ])
      && v_fetch_addr == $past(v_desc_start_in))
      else $error("descriptor load wrong");
   add_irq_a: assert property (wr_v_head |=>
      v_queue_add_irq == !$past(st_q.v_ctrl[ocd_pkg::CTRL_ADD_IRQ]))
      else $error("head queued irq wrong");
   list_end_a: assert property (v_list_end_irq |->
      $past(st_q.v_ctrl[ocd_pkg::CTRL_END_IRQ]) && st_q.vst == ocd_pkg::V_IDLE)
      else $error("list end irq without enable");
   y_room_a: assert property (y_req && $past(st_q.cfg[ocd_pkg::CFG_YBL_LO +: 2])
      == ocd_pkg::BL_EIGHT |-> $past(y_fifo_room) >= ocd_pkg::W8
      && y_hburst != ocd_pkg::HB_INCR16)
      else $error("y burst started too early or too long");
   four_cap_a: assert property (c_req && $past(st_q.cfg[ocd_pkg::CFG_CBL_LO +: 2])
      == ocd_pkg::BL_FOUR |-> y_beats <= ocd_pkg::W16[4:0] && c_beats <= ocd_pkg::W4[4:0])
      else $error("four word setting exceeded");
   fixed_only_a: assert property ($past(st_q.cfg[ocd_pkg::CFG_FIXED]) && y_req |->
      y_hburst != ocd_pkg::HB_INCR)
      else $error("undefined length burst while disallowed");
   bus_lock_a: assert property (bus_lock |->
      $past(rotate_active) && !$past(st_q.cfg[ocd_pkg::CFG_LOCK_OFF]))
      else $error("bus locked without rotation");
   rsv_read_a: assert property (reg_rd && reg_addr == ocd_pkg::V_CTRL_ADDR |=>
      (reg_rdata & ~ocd_pkg::V_CTRL_MASK) == ocd_pkg::RESET_WORD)
      else $error("reserved bits read nonzero");

   chain_c: cover property (v_xfer_done && st_q.vst == ocd_pkg::V_RUN ##1 v_desc_req);
   incr_c: cover property (y_req && y_hburst == ocd_pkg::HB_INCR);
   sixteen_c: cover property (c_req && c_hburst == ocd_pkg::HB_INCR16);
   lock_c: cover property (bus_lock);

endmodule

// ### test/ocd_mem_model.sv
// descriptor memory and plane fetch model on the far side of the v channel
`timescale 1ns/100ps
module ocd_mem_model
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // answer pace in cycles
   input wire logic [3:0] ack_delay,
   // descriptor link
   input wire logic v_desc_req,
   input wire logic [31:0] v_desc_addr,
   output logic v_desc_ack,
   output logic [31:0] v_desc_start_in,
   output logic [31:0] v_desc_next_in,
   output logic v_xfer_done
);
   logic [3:0] wait_q;
   logic [2:0] run_q;

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wait_q <= 4'h0;
         run_q <= 3'h0;
         v_desc_ack <= 1'h0;
         v_xfer_done <= 1'h0;
         v_desc_start_in <= 32'h00000000;
         v_desc_next_in <= 32'h00000000;
      end
      else
      begin
         v_desc_ack <= 1'h0;
         v_xfer_done <= 1'h0;
         // descriptor lines hold no stale value outside the ack cycle
         v_desc_start_in <= ~v_desc_start_in;
         v_desc_next_in <= ~v_desc_next_in;
         if (v_desc_req && !v_desc_ack && run_q == 3'h0)
         begin
            if (wait_q == ack_delay)
            begin
               v_desc_ack <= 1'h1;
               v_desc_start_in <= v_desc_addr + 32'h00001000;
               // a descriptor with address bit 6 set links to the next slot
               v_desc_next_in <= v_desc_addr[6] ? v_desc_addr + 32'h00000040 : 32'h00000000;
               wait_q <= 4'h0;
               run_q <= 3'h4;
            end
            else
               wait_q <= wait_q + 4'h1;
         end
         if (run_q != 3'h0)
            run_q <= run_q - 3'h1;
         if (run_q == 3'h1)
            v_xfer_done <= 1'h1;
      end
   end
endmodule

// ### test/testbench.sv
// self-checking bench of the overlay chroma descriptor dma
`timescale 1ns/100ps
module testbench;
   typedef struct packed {logic [31:0] a; logic [31:0] w; logic [31:0] r;} ocd_rrow_t;
   typedef struct packed {logic [1:0] bl; logic fix; logic [5:0] room; logic rq;
      logic [2:0] hb; logic [4:0] bt;} ocd_prow_t;
   logic core_clk, nrst, reg_wr, reg_rd, uuv_list_end, uuv_desc_fetch_en, uuv_list_end_irq;
   logic [31:0] reg_addr, reg_wdata, reg_rdata, uuv_next_desc_addr, v_desc_addr;
   logic [31:0] v_desc_start_in, v_desc_next_in, v_fetch_addr, rd_v;
   logic v_desc_req, v_desc_ack, v_xfer_done, y_req, c_req, rotate_active;
   logic v_xfer_done_irq, v_desc_loaded_irq, v_queue_add_irq, v_list_end_irq;
   logic [5:0] y_fifo_room, c_fifo_room;
   logic [15:0] y_beats_left, c_beats_left;
   logic [2:0] y_hburst, c_hburst;
   logic [4:0] y_beats, c_beats;
   logic rotation_opt_en, bus_lock;
   logic [3:0] ack_delay;
   logic [31:0] ack_log[$];
   logic [31:0] ctl;
   int n_add, n_load, n_xfer, n_end, n_uend, miscompares, checked;
   ocd_rrow_t regs[7];
   ocd_prow_t rows[12];

   ocd_chroma_dma u_ocd_chroma_dma (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .uuv_list_end, .uuv_desc_fetch_en, .uuv_next_desc_addr,
      .uuv_list_end_irq, .v_desc_req, .v_desc_addr, .v_desc_ack, .v_desc_start_in,
      .v_desc_next_in, .v_xfer_done, .v_fetch_addr, .v_xfer_done_irq, .v_desc_loaded_irq,
      .v_queue_add_irq, .v_list_end_irq, .y_fifo_room, .y_beats_left, .y_req, .y_hburst,
      .y_beats, .c_fifo_room, .c_beats_left, .c_req, .c_hburst, .c_beats, .rotate_active,
      .rotation_opt_en, .bus_lock);
   ocd_mem_model u_ocd_mem_model (.core_clk, .nrst, .ack_delay, .v_desc_req, .v_desc_addr,
      .v_desc_ack, .v_desc_start_in, .v_desc_next_in, .v_xfer_done);

   initial
   begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end

   // event counters
   always @(posedge core_clk)
   begin
      if (v_queue_add_irq === 1'h1) n_add++;
      if (v_desc_loaded_irq === 1'h1) n_load++;
      if (v_xfer_done_irq === 1'h1) n_xfer++;
      if (v_list_end_irq === 1'h1) n_end++;
      if (uuv_list_end_irq === 1'h1) n_uend++;
      if (v_desc_ack === 1'h1 && v_desc_req === 1'h1) ack_log.push_back(v_desc_addr);
   end

   task automatic close_out;
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask

   task automatic rd(input logic [31:0] a);
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 rd_v = reg_rdata;
   endtask

   task automatic clr;
      n_add = 0; n_load = 0; n_xfer = 0; n_end = 0; n_uend = 0;
      ack_log.delete();
   endtask

   task automatic wait_acks(input int n);
      for (int i = 0; i < 200 && ack_log.size() < n; i++) @(posedge core_clk);
      if (ack_log.size() < n)
      begin
         miscompares++;
         close_out();
      end
   endtask

   initial
   begin
      nrst = 1'h0; reg_wr = 1'h0; reg_rd = 1'h0; reg_addr = 32'h0; reg_wdata = 32'h0;
      uuv_list_end = 1'h0; y_fifo_room = 6'h0; c_fifo_room = 6'h0; rotate_active = 1'h1;
      y_beats_left = 16'h0064; c_beats_left = 16'h0064; ack_delay = 4'h2;
      miscompares = 0; checked = 0;
      clr();
      regs = '{'{ocd_pkg::UUV_CTRL_ADDR, 32'hFFFFFFFF, 32'h00000021},
         '{ocd_pkg::UUV_NEXT_ADDR, 32'h20001234, 32'h20001234},
         '{ocd_pkg::V_START_ADDR, 32'h30005678, 32'h30005678},
         '{ocd_pkg::V_NEXT_ADDR, 32'h3000ABC0, 32'h3000ABC0},
         '{ocd_pkg::V_CTRL_ADDR, 32'hFFFFFFFE, 32'h0000003C},
         '{ocd_pkg::BUS_CFG_ADDR, 32'hFFFFFFFF, 32'h000031F0},
         '{32'hF80382D0, 32'hFFFFFFFF, 32'h00000000}};
      // hburst single 0, incr 1, incr4 3, incr8 5, incr16 7
      rows = '{'{2'h0, 1'h0, 6'h01, 1'h1, 3'h0, 5'h01}, '{2'h0, 1'h0, 6'h02, 1'h1, 3'h1, 5'h02},
         '{2'h0, 1'h0, 6'h03, 1'h1, 3'h1, 5'h03}, '{2'h0, 1'h1, 6'h03, 1'h1, 3'h0, 5'h01},
         '{2'h0, 1'h0, 6'h0A, 1'h1, 3'h5, 5'h08}, '{2'h0, 1'h0, 6'h10, 1'h1, 3'h7, 5'h10},
         '{2'h1, 1'h0, 6'h03, 1'h0, 3'h0, 5'h00}, '{2'h1, 1'h0, 6'h10, 1'h1, 3'h3, 5'h04},
         '{2'h2, 1'h0, 6'h07, 1'h0, 3'h0, 5'h00}, '{2'h2, 1'h0, 6'h10, 1'h1, 3'h5, 5'h08},
         '{2'h3, 1'h0, 6'h0F, 1'h0, 3'h0, 5'h00}, '{2'h3, 1'h1, 6'h10, 1'h1, 3'h7, 5'h10}};
      repeat (5) @(posedge core_clk);
      nrst <= 1'h1;
      // ---------------------------------------
      // register reset values, masks and access
      // ---------------------------------------
      foreach (regs[i])
      begin
         rd(regs[i].a);
         chk("reset value", ocd_pkg::RESET_WORD, rd_v);
         wr(regs[i].a, regs[i].w);
         rd(regs[i].a);
         chk("readback", regs[i].r, rd_v);
      end
      chk("uuv fetch", 32'h1, uuv_desc_fetch_en);
      chk("uuv next", 32'h20001234, uuv_next_desc_addr);
      chk("v fetch addr", 32'h30005678, v_fetch_addr);
      chk("rotation opt", 32'h0, rotation_opt_en);
      // ---------------------------------------
      // burst planner for both channels
      // ---------------------------------------
      foreach (rows[i])
      begin
         wr(ocd_pkg::BUS_CFG_ADDR, {23'h0, rows[i].fix, rows[i].bl, rows[i].bl, 4'h0});
         y_fifo_room <= rows[i].room;
         c_fifo_room <= rows[i].room;
         repeat (3) @(posedge core_clk);
         #1;
         chk("y req", rows[i].rq, y_req);
         chk("c req", rows[i].rq, c_req);
         chk("lock", rows[i].rq, bus_lock);
         chk("rotation opt", 32'h1, rotation_opt_en);
         if (rows[i].rq)
         begin
            chk("y burst", {rows[i].hb, rows[i].bt}, {y_hburst, y_beats});
            chk("c burst", {rows[i].hb, rows[i].bt}, {c_hburst, c_beats});
         end
      end
      wr(ocd_pkg::BUS_CFG_ADDR, 32'h00002000);
      repeat (3) @(posedge core_clk);
      #1 chk("lock off", 32'h0, bus_lock);
      // short remainder on y, empty chroma channel, rotation idle
      wr(ocd_pkg::BUS_CFG_ADDR, 32'h00000000);
      y_beats_left <= 16'h0003;
      c_beats_left <= 16'h0000;
      rotate_active <= 1'h0;
      repeat (3) @(posedge core_clk);
      rotate_active <= 1'h1;
      y_beats_left <= 16'h0064;
      c_beats_left <= 16'h0064;
      #1;
      chk("y short burst", {ocd_pkg::HB_INCR, 5'h03}, {y_hburst, y_beats});
      chk("c empty", 32'h0, c_req);
      chk("lock idle", 32'h0, bus_lock);
      // ---------------------------------------
      // descriptor chain with irq polarities
      // ---------------------------------------
      for (int k = 0; k < 3; k++)
      begin
         ctl = (k == 0) ? 32'h21 : (k == 1) ? 32'h1D : 32'h25;
         ack_delay <= (k == 0) ? 4'h3 : 4'h0;
         wr(ocd_pkg::V_CTRL_ADDR, ctl);
         clr();
         wr(ocd_pkg::V_HEAD_ADDR, 32'h30000040);
         wait_acks(2);
         repeat (12) @(posedge core_clk);
         chk("head addr", 32'h30000040, ack_log[0]);
         chk("next addr", 32'h30000080, ack_log[1]);
         chk("fetch addr", 32'h30001080, v_fetch_addr);
         chk("add irq", {31'h0, !ctl[4]}, n_add);
         chk("load irq", ctl[3] ? 32'h0 : 32'h2, n_load);
         chk("xfer irq", ctl[2] ? 32'h0 : 32'h2, n_xfer);
         chk("end irq", {31'h0, ctl[5]}, n_end);
      end
      rd(ocd_pkg::V_HEAD_ADDR);
      chk("head reg", 32'h30000040, rd_v);
      wr(ocd_pkg::V_CTRL_ADDR, 32'h3C);
      clr();
      wr(ocd_pkg::V_HEAD_ADDR, 32'h30000040);
      repeat (20) @(posedge core_clk);
      chk("fetch off", 32'h0, ack_log.size());
      chk("req off", 32'h0, v_desc_req);
      // ---------------------------------------
      // uuv end-of-list gating and second reset
      // ---------------------------------------
      for (int k = 0; k < 2; k++)
      begin
         wr(ocd_pkg::UUV_CTRL_ADDR, k ? 32'h01 : 32'h21);
         clr();
         uuv_list_end <= 1'h1;
         @(posedge core_clk);
         uuv_list_end <= 1'h0;
         repeat (3) @(posedge core_clk);
         chk("uuv end irq", k ? 32'h0 : 32'h1, n_uend);
      end
      nrst <= 1'h0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'h1;
      rd(ocd_pkg::BUS_CFG_ADDR);
      chk("cfg after reset", ocd_pkg::RESET_WORD, rd_v);
      chk("rotation opt", 32'h1, rotation_opt_en);
      close_out();
   end
endmodule
